/* File: core/ahb_pkg.sv */
// Package with constants, states and carrier structs for the async host bus and DMA handshake block
package ahb_pkg;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;                  // 20 MHz reference clock
  localparam int ACK_MIN_CLKS    = 2;                   // Least select-to-ack delay, in clocks
  localparam int ACK_MAX_CLKS    = 4;                   // Longest select-to-ack delay, in clocks
  localparam int SVC_DELAY_CLKS  = 20;                  // Extra ack delay after service cycles
  localparam int ACK_NEG_NS      = 40;                  // Longest ack negation time
  localparam int ACK_NEG_CLKS    = (ACK_NEG_NS / CLK_PERIOD_NS) < 1 ? 1 : (ACK_NEG_NS / CLK_PERIOD_NS);
  localparam int RST_MIN_CLKS    = 10;                  // Least reset pulse width
  localparam int PHASE_START_CLK = 2;                   // Phase one starts after this release edge
  localparam int DMA_DRIVE_CLKS  = 1;                   // Clocks from dma ack to data drive
  localparam int DMA_HOLD_EDGE   = 2;                   // Edge that decides ack-controlled release
  localparam int DMA_SHORT_EDGE  = 3;                   // Release edge for short back-to-back acks
  localparam int CNT_W           = 5;                   // Width of delay counters

  localparam logic [CNT_W-1:0] ACK_WAIT_NORM = CNT_W'(ACK_MIN_CLKS);
  localparam logic [CNT_W-1:0] ACK_WAIT_SVC  = CNT_W'(ACK_MIN_CLKS + SVC_DELAY_CLKS);
  localparam logic [CNT_W-1:0] HOLD_EDGE     = CNT_W'(DMA_HOLD_EDGE);
  localparam logic [CNT_W-1:0] SHORT_EDGE    = CNT_W'(DMA_SHORT_EDGE);
  localparam logic [CNT_W-1:0] DRIVE_EDGE    = CNT_W'(DMA_DRIVE_CLKS);
  localparam logic [CNT_W-1:0] PHASE_EDGE    = CNT_W'(PHASE_START_CLK);
  localparam logic [CNT_W-1:0] CNT_ZERO      = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE       = 5'h01;

  // ----------------------------------------------------------------
  // Host cycle state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AHB_IDLE = 4'h1,
    AHB_WAIT = 4'h2,
    AHB_ACK  = 4'h4,
    AHB_SVC  = 4'h8
  } ahb_host_st_t;

  // DMA read state machine, one-hot
  typedef enum logic [2:0] {
    AHB_DIDLE = 3'h1,
    AHB_DACT  = 3'h2,
    AHB_DREL  = 3'h4
  } ahb_dma_st_t;

  // Host strobe group as seen at the pins
  typedef struct packed {
    logic chip_sel_n;        // Chip select, low active
    logic data_strobe_n;     // Data strobe, low active
    logic daisy_grant_in_n;  // Daisy grant in, low active
    logic service_ack_n;     // Service acknowledge, low active
    logic read_not_write;    // High for read
  } ahb_host_ctl_t;

  // DMA handshake from the user side of the block
  typedef struct packed {
    logic req;               // Core wants a transfer
    logic last;              // This transfer is the last one
    logic rd;                // Transfer is a read towards the bus
  } ahb_dma_ctl_t;

endpackage

/* File: core/ahb_host_port.sv */
// Host bus slave timing engine with select/strobe cycles, transfer ack and DMA handshake
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module ahb_host_port #(
  parameter int DATA_W = 16                                  // Host data bus width
) (
  input  wire logic                  ref_clk,                // 20 MHz clock
  input  wire logic                  reset,                  // Synchronous reset, high
  input  wire ahb_pkg::ahb_host_ctl_t host_ctl,              // Select, strobe, grant, service ack
  input  wire logic                  eos_write,              // Core reports end_of_service_reg write
  input  wire logic [DATA_W-1:0]     host_data_bus_in,       // Data bus level
  output logic      [DATA_W-1:0]     host_data_bus_out,      // Data bus drive value
  output logic                       host_data_bus_oe_n,     // Data bus enable, low drives
  output logic                       transfer_ack_n_out,     // Ack drive value
  output logic                       transfer_ack_n_oe_n,    // Ack enable, low drives
  input  wire logic [DATA_W-1:0]     rd_data,                // Core read data
  output logic      [DATA_W-1:0]     wr_data,                // Captured host or DMA write data
  output logic                       wr_strobe,              // One-cycle pulse with wr_data
  output logic                       host_access,            // One-cycle pulse on host access
  input  wire ahb_pkg::ahb_dma_ctl_t dma_ctl,                // Core DMA request
  input  wire logic                  dma_ack_n,              // DMA acknowledge, low active
  output logic                       dma_req_n,              // DMA request, low active
  output logic                       cycle_phase_one         // High in the phase-one cycle
);
  import ahb_pkg::*;

  initial begin
    if (DATA_W < 1 || DATA_W > 32) $error("DATA_W out of range");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic sel_active(input ahb_host_ctl_t c);
    sel_active = (~c.chip_sel_n | ~c.daisy_grant_in_n) & ~c.data_strobe_n;
  endfunction

  function automatic logic sel_idle(input ahb_host_ctl_t c);
    sel_idle = (c.chip_sel_n & c.daisy_grant_in_n) | c.data_strobe_n;
  endfunction

  // ----------------------------------------------------------------
  // Reset phase alignment
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] phase_cnt_q, phase_cnt_d;
  logic             phase_q, phase_d;

  // Count edges after release so phase one lands on the second edge
  always_comb begin
    phase_cnt_d = phase_cnt_q;
    phase_d     = 1'b0;
    if (phase_cnt_q != PHASE_EDGE) begin
      phase_cnt_d = phase_cnt_q + CNT_ONE;
      phase_d     = (phase_cnt_q + CNT_ONE) == PHASE_EDGE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_cnt_q <= CNT_ZERO;
      phase_q     <= 1'b0;
    end else begin
      phase_cnt_q <= phase_cnt_d;
      phase_q     <= phase_d;
    end
  end

  // ----------------------------------------------------------------
  // Host cycle: select, wait, ack, release
  // ----------------------------------------------------------------
  ahb_host_st_t     hst_q, hst_d;
  logic [CNT_W-1:0] wait_q, wait_d;
  logic             svc_pend_q, svc_pend_d;
  logic             ack_q, ack_d;
  logic             rd_oe_q, rd_oe_d;
  logic [DATA_W-1:0] rd_q, rd_d;
  logic             acc_q, acc_d;

  // Service cycles and end-of-service writes arm the long delay for the next access
  always_comb begin
    hst_d      = hst_q;
    wait_d     = wait_q;
    svc_pend_d = svc_pend_q | eos_write;
    ack_d      = ack_q;
    rd_oe_d    = rd_oe_q;
    rd_d       = rd_q;
    acc_d      = 1'b0;
    unique case (hst_q)
      AHB_IDLE: begin
        if (sel_active(host_ctl)) begin
          acc_d = 1'b1;
          if (!host_ctl.service_ack_n) begin
            hst_d      = AHB_SVC;
            svc_pend_d = 1'b1;
          end else begin
            hst_d  = AHB_WAIT;
            // Long wait replaces the normal one, then the arming clears
            wait_d = svc_pend_q ? ACK_WAIT_SVC - CNT_ONE : ACK_WAIT_NORM - CNT_ONE;
            if (!eos_write) svc_pend_d = 1'b0;
          end
        end
      end
      AHB_WAIT: begin
        if (sel_idle(host_ctl)) begin
          hst_d = AHB_IDLE;                                  // Aborted cycle, no ack
        end else if (wait_q == CNT_ZERO) begin
          hst_d   = AHB_ACK;
          ack_d   = 1'b1;
          rd_oe_d = host_ctl.read_not_write & host_ctl.service_ack_n;
          rd_d    = rd_data;
        end else begin
          wait_d = wait_q - CNT_ONE;
        end
      end
      AHB_SVC: begin
        // Service ack cycle is acknowledged at normal pace
        hst_d  = AHB_WAIT;
        wait_d = ACK_WAIT_NORM - CNT_ONE - CNT_ONE;
      end
      AHB_ACK: begin
        if (sel_idle(host_ctl)) begin
          hst_d   = AHB_IDLE;
          ack_d   = 1'b0;
          rd_oe_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hst_q      <= AHB_IDLE;
      wait_q     <= CNT_ZERO;
      svc_pend_q <= 1'b0;
      ack_q      <= 1'b0;
      rd_oe_q    <= 1'b0;
      rd_q       <= '0;
      acc_q      <= 1'b0;
    end else begin
      hst_q      <= hst_d;
      wait_q     <= wait_d;
      svc_pend_q <= svc_pend_d;
      ack_q      <= ack_d;
      rd_oe_q    <= rd_oe_d;
      rd_q       <= rd_d;
      acc_q      <= acc_d;
    end
  end

  // ----------------------------------------------------------------
  // DMA handshake and read bus control
  // ----------------------------------------------------------------
  ahb_dma_st_t      dst_q, dst_d;
  logic [CNT_W-1:0] dcnt_q, dcnt_d;
  logic             req_q, req_d;
  logic             doe_q, doe_d;
  logic [DATA_W-1:0] dd_q, dd_d;
  logic             ack_prev_q;

  // Ack release after the second edge hands control of the bus to the ack itself
  always_comb begin
    dst_d = dst_q;
    dcnt_d = dcnt_q;
    doe_d = doe_q;
    dd_d  = dd_q;
    req_d = dma_ctl.req;
    unique case (dst_q)
      AHB_DIDLE: begin
        if (!dma_ack_n && ack_prev_q) begin
          dcnt_d = CNT_ONE;
          if (dma_ctl.rd) begin
            dst_d = AHB_DACT;
            dd_d  = rd_data;                                 // Latched now, driven one clock later
          end
          if (dma_ctl.last) req_d = 1'b0;
        end else if (dcnt_q == DRIVE_EDGE) begin
          dcnt_d = dcnt_q + CNT_ONE;                         // A DMA write is captured only once
        end
      end
      AHB_DACT: begin
        if (dcnt_q != SHORT_EDGE) dcnt_d = dcnt_q + CNT_ONE;
        // Driving at the take edge would beat the earliest valid point after the ack
        if (dcnt_q == DRIVE_EDGE) doe_d = 1'b1;
        if (dcnt_q < HOLD_EDGE && dma_ack_n) begin
          dst_d = AHB_DREL;
        end else if (dcnt_q >= HOLD_EDGE && dma_ack_n) begin
          dst_d = AHB_DIDLE;
          doe_d = 1'b0;
        end
      end
      AHB_DREL: begin
        // Early release still waits for the next edge, capped at the third edge
        if (dcnt_q < SHORT_EDGE) dcnt_d = dcnt_q + CNT_ONE;
        dst_d = AHB_DIDLE;
        doe_d = 1'b0;
      end
    endcase
    if (dst_q != AHB_DIDLE && dma_ctl.last) req_d = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dst_q      <= AHB_DIDLE;
      dcnt_q     <= CNT_ZERO;
      req_q      <= 1'b0;
      doe_q      <= 1'b0;
      dd_q       <= '0;
      ack_prev_q <= 1'b1;
    end else begin
      dst_q      <= dst_d;
      dcnt_q     <= dcnt_d;
      req_q      <= req_d;
      doe_q      <= doe_d;
      dd_q       <= dd_d;
      ack_prev_q <= dma_ack_n;
    end
  end

  // ----------------------------------------------------------------
  // Write capture: at the ack edge of a host write, or one clock after a DMA write ack
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] wd_q, wd_d;
  logic              ws_q, ws_d;

  // Sampling at the ack edge leaves the host its full clock of data setup
  always_comb begin
    wd_d = wd_q;
    ws_d = 1'b0;
    if ((hst_q == AHB_WAIT) && (wait_d == CNT_ZERO) && !host_ctl.read_not_write
        && host_ctl.service_ack_n && sel_active(host_ctl) && (wait_q == CNT_ZERO)) begin
      wd_d = host_data_bus_in;
      ws_d = 1'b1;
    end else if ((dst_q == AHB_DIDLE) && !dma_ack_n && !ack_prev_q && !dma_ctl.rd && dcnt_q == DRIVE_EDGE) begin
      wd_d = host_data_bus_in;
      ws_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wd_q <= '0;
      ws_q <= 1'b0;
    end else begin
      wd_q <= wd_d;
      ws_q <= ws_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign host_data_bus_out   = rd_oe_q ? rd_q : dd_q;
  assign host_data_bus_oe_n  = ~(rd_oe_q | doe_q);
  assign transfer_ack_n_out  = ~ack_q;
  assign transfer_ack_n_oe_n = ~ack_q;                       // Open drain: driven only while low
  assign wr_data             = wd_q;
  assign wr_strobe           = ws_q;
  assign host_access         = acc_q;
  assign dma_req_n           = ~req_q;
  assign cycle_phase_one     = phase_q;

endmodule

/* File: test/ahb_host_port_properties.sv */
// Concurrent timing checks for the host port, bound to its ports
module ahb_host_port_properties (
  input wire logic                   ref_clk,             // Clock
  input wire logic                   reset,               // Sync reset
  input wire ahb_pkg::ahb_host_ctl_t host_ctl,            // Host strobes
  input wire logic                   eos_write,           // Service end write
  input wire ahb_pkg::ahb_dma_ctl_t  dma_ctl,             // Core DMA request
  input wire logic                   dma_ack_n,           // DMA ack
  input wire logic                   host_data_bus_oe_n,  // Bus enable
  input wire logic                   transfer_ack_n_oe_n, // Ack enable
  input wire logic                   dma_req_n,           // DMA request
  input wire logic                   cycle_phase_one      // Phase one
);
  timeunit 1ns;
  timeprecision 1ns;
  import ahb_pkg::*;
  logic       sel, start, sel_q, pend_d, pend_q;
  logic [2:0] quiet_d, quiet_q;
  // Access seen and first cycle of it
  assign sel   = (!host_ctl.chip_sel_n || !host_ctl.daisy_grant_in_n) && !host_ctl.data_strobe_n;
  assign start = sel && !sel_q;
  // Mirror of the service delay flag; idle run saturates so the count never wraps
  always_comb begin
    pend_d  = start ? !host_ctl.service_ack_n : pend_q;
    pend_d  = pend_d || eos_write;
    quiet_d = (sel || !dma_ack_n) ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
  end
  // Helper state
  always_ff @(posedge ref_clk) begin
    sel_q   <= reset ? 1'b0 : sel;
    pend_q  <= reset ? 1'b0 : pend_d;
    quiet_q <= reset ? 3'h0 : quiet_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_ack_norm; start && !(pend_q && host_ctl.service_ack_n) |-> ##[3:4] $fell(transfer_ack_n_oe_n); endproperty
  a_ack_norm: assert property (p_ack_norm) else $error("plain ack out of window");
  property p_ack_slow; start && pend_q && host_ctl.service_ack_n |-> ##[23:24] $fell(transfer_ack_n_oe_n); endproperty
  a_ack_slow: assert property (p_ack_slow) else $error("delayed ack out of window");
  property p_ack_rel; !transfer_ack_n_oe_n && !sel |=> transfer_ack_n_oe_n; endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack held after select idle");
  property p_bus_wr; sel && sel_q && !host_ctl.read_not_write |-> host_data_bus_oe_n; endproperty
  a_bus_wr: assert property (p_bus_wr) else $error("bus driven in write");
  property p_bus_quiet; quiet_q >= 3'h5 |-> host_data_bus_oe_n; endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("bus driven while idle");
  property p_dma_drive; $fell(dma_ack_n) && dma_ctl.rd |-> ##2 !host_data_bus_oe_n; endproperty
  a_dma_drive: assert property (p_dma_drive) else $error("DMA read data late");
  property p_dma_hold; (dma_ctl.rd && !dma_ack_n) [*4] |-> !host_data_bus_oe_n; endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("DMA read bus dropped early");
  property p_dma_short; $fell(dma_ack_n) ##1 dma_ack_n |-> ##[1:3] host_data_bus_oe_n; endproperty
  a_dma_short: assert property (p_dma_short) else $error("short DMA ack not released");
  property p_req_last; $fell(dma_ack_n) && dma_ctl.last |-> ##[1:2] dma_req_n; endproperty
  a_req_last: assert property (p_req_last) else $error("last DMA request held");
  property p_phase; $fell(reset) |-> !cycle_phase_one ##1 !cycle_phase_one ##1 cycle_phase_one; endproperty
  a_phase: assert property (p_phase) else $error("phase one missing");
  c_slow: cover property (start && pend_q && host_ctl.service_ack_n);
  c_svc: cover property (start && !host_ctl.service_ack_n);
  c_short: cover property ($fell(dma_ack_n) ##1 dma_ack_n);
endmodule
bind ahb_host_port ahb_host_port_properties u_props (.ref_clk(ref_clk), .reset(reset), .host_ctl(host_ctl),
  .eos_write(eos_write), .dma_ctl(dma_ctl), .dma_ack_n(dma_ack_n), .host_data_bus_oe_n(host_data_bus_oe_n),
  .transfer_ack_n_oe_n(transfer_ack_n_oe_n), .dma_req_n(dma_req_n), .cycle_phase_one(cycle_phase_one));

/* File: test/ahb_host_model.sv */
// Behavioural host CPU and DMA controller facing the host port
module ahb_host_model (
  input  wire logic           ref_clk,   // Clock
  input  wire logic [15:0]    bus_out,   // Device drive value
  input  wire logic           bus_oe_n,  // Device drive enable
  input  wire logic           ack_out,   // Ack drive value
  input  wire logic           ack_oe_n,  // Ack enable
  output ahb_pkg::ahb_host_ctl_t ctl,    // Select and strobes
  output logic                dma_ack_n, // DMA acknowledge
  output logic [15:0]         bus        // Resolved data bus
);
  timeunit 1ns;
  timeprecision 1ns;
  import ahb_pkg::*;
  logic        drv, ack_w;
  logic [15:0] wd, last_q;
  // Ack has a pull-up; a released bus shows the inverse of its last level
  assign ack_w = ack_oe_n ? 1'b1 : ack_out;
  assign bus   = !bus_oe_n ? bus_out : (drv ? wd : ~last_q);
  // Bus history for the released pattern
  always @(posedge ref_clk) last_q <= bus;
  initial begin
    ctl = '1;
    dma_ack_n = 1'b1;
    drv = 1'b0;
    wd = 16'h0000;
    last_q = 16'h0000;
  end
  // One select cycle; waits for the ack rather than counting wait states
  task automatic host_cycle(input logic rnw, svc, gnt, input logic [15:0] d, output logic [15:0] q, output int lat);
    lat = 0;
    @(negedge ref_clk);
    ctl = {gnt, 1'b0, !gnt, !svc, rnw};
    wd = d;
    drv = !rnw;
    // Ack is looked at on falling edges, half a clock after the device moves it
    @(negedge ref_clk);
    lat = 1;
    while (ack_w !== 1'b0 && lat < 40) begin
      @(negedge ref_clk);
      lat++;
    end
    q = bus;
    ctl = '1;
    drv = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  // One DMA transfer; write data goes out with the ack
  task automatic dma(input logic rd, input int hold, input logic [15:0] d, output logic [15:0] q);
    @(negedge ref_clk);
    dma_ack_n = 1'b0;
    wd = d;
    drv = !rd;
    repeat (hold) @(posedge ref_clk);
    q = bus;
    @(negedge ref_clk);
    dma_ack_n = 1'b1;
    drv = 1'b0;
  endtask
endmodule

/* File: test/async_host_bus_dma_handshake_tb.sv */
// Self-checking bench for the host port timing engine
module async_host_bus_dma_handshake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ahb_pkg::*;
  logic          ref_clk, reset, eos_write, bus_oe_n, ack_out, ack_oe_n, wr_strobe, host_access;
  logic          dma_ack_n, dma_req_n, cycle_phase_one;
  logic [15:0]   bus, bus_out, rd_data, wr_data, wr_last, q;
  ahb_host_ctl_t host_ctl;
  ahb_dma_ctl_t  dma_ctl;
  int            num_errors, samples_checked, wr_n, acc_n, lat, drv_n;
  ahb_host_port #(.DATA_W(16)) DUT (.ref_clk(ref_clk), .reset(reset), .host_ctl(host_ctl),
    .eos_write(eos_write), .host_data_bus_in(bus), .host_data_bus_out(bus_out), .host_data_bus_oe_n(bus_oe_n),
    .transfer_ack_n_out(ack_out), .transfer_ack_n_oe_n(ack_oe_n), .rd_data(rd_data), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .host_access(host_access), .dma_ctl(dma_ctl), .dma_ack_n(dma_ack_n),
    .dma_req_n(dma_req_n), .cycle_phase_one(cycle_phase_one));
  ahb_host_model u_host (.ref_clk(ref_clk), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .ack_out(ack_out),
    .ack_oe_n(ack_oe_n), .ctl(host_ctl), .dma_ack_n(dma_ack_n), .bus(bus));
  // Clock, and counts of write, access and bus drive cycles
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Counted on the falling edge, away from the edge that moves the outputs
  always @(negedge ref_clk) begin
    if (wr_strobe === 1'b1) begin
      wr_n++;
      wr_last = wr_data;
    end
    if (host_access === 1'b1) acc_n++;
    if (bus_oe_n === 1'b0) drv_n++;
  end
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Long enough reset, then phase one two edges after release
  task automatic t_reset;
    reset = 1'b1;
    repeat (10) @(negedge ref_clk);
    check(bus_oe_n === 1'b1 && ack_oe_n === 1'b1 && dma_req_n === 1'b1, "reset outputs");
    reset = 1'b0;
    @(negedge ref_clk);
    check(cycle_phase_one === 1'b0, "phase early");
    @(negedge ref_clk);
    check(cycle_phase_one === 1'b1, "phase missing");
    $display("test reset done");
  endtask
  // Read by select or grant, with the expected ack window
  task automatic t_read(input logic gnt, svc, input int lo);
    int a0;
    int d0;
    a0 = acc_n;
    d0 = drv_n;
    rd_data = gnt ? 16'h3c5a : 16'ha5c3;
    u_host.host_cycle(1'b1, svc, gnt, 16'h0000, q, lat);
    // Ack launched lo to lo+2 edges after the take is seen one falling edge later
    check(lat > lo && lat <= lo + 3, "ack latency");
    if (svc) check(drv_n == d0, "service cycle drove bus");
    else check(q === rd_data, "read data");
    check(ack_oe_n === 1'b1 && bus_oe_n === 1'b1, "not released");
    check(acc_n == a0 + 1, "access pulse");
    $display("test read done");
  endtask
  task automatic t_write;
    int w0;
    w0 = wr_n;
    u_host.host_cycle(1'b0, 1'b0, 1'b0, 16'h1234, q, lat);
    check(wr_n == w0 + 1 && wr_last === 16'h1234, "host write");
    $display("test write done");
  endtask
  // Service cycle and end-of-service write each delay the next access
  task automatic t_service;
    t_read(1'b0, 1'b1, 2);
    t_read(1'b0, 1'b0, 22);
    t_read(1'b1, 1'b0, 2);
    eos_write = 1'b1;
    @(negedge ref_clk);
    eos_write = 1'b0;
    t_read(1'b0, 1'b0, 22);
    $display("test service done");
  endtask
  // Stretched last read, short read, then a write
  task automatic t_dma;
    int w0;
    dma_ctl = '{req: 1'b1, last: 1'b0, rd: 1'b1};
    rd_data = 16'h0ff0;
    repeat (2) @(negedge ref_clk);
    check(dma_req_n === 1'b0, "request missing");
    dma_ctl.last = 1'b1;
    u_host.dma(1'b1, 6, 16'h0000, q);
    check(q === 16'h0ff0 && dma_req_n === 1'b1, "stretched read");
    u_host.dma(1'b1, 1, 16'h0000, q);
    repeat (4) @(negedge ref_clk);
    check(bus_oe_n === 1'b1, "short ack bus");
    dma_ctl = '{req: 1'b1, last: 1'b0, rd: 1'b0};
    w0 = wr_n;
    u_host.dma(1'b0, 3, 16'hbeef, q);
    repeat (2) @(negedge ref_clk);
    check(wr_n == w0 + 1 && wr_last === 16'hbeef, "DMA write");
    dma_ctl = '0;
    $display("test dma done");
  endtask
  // Main sequence
  initial begin
    reset = 1'b1;
    eos_write = 1'b0;
    rd_data = 16'h0000;
    dma_ctl = '0;
    num_errors = 0;
    samples_checked = 0;
    wr_n = 0;
    acc_n = 0;
    drv_n = 0;
    t_reset();
    t_read(1'b0, 1'b0, 2);
    t_read(1'b1, 1'b0, 2);
    t_write();
    t_service();
    t_dma();
    close_out();
  end
  // Watchdog well past the expected run of under 150 cycles
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule
